//--- verilog/dpdc_top.sv
// Purpose: Device-side power-down entry and exit control
// Assumes: Pins sampled by sys_clk_i at 200 MHz; CK much slower
// Notes:   Counters run on sys_clk_i, exit timing in system cycles
//
// Contract
// [RL1] Controller issues one extra refresh after self-refresh exit.
// [RL2] Power-down entered when CKE sampled low with NOP or deselect.
// [RL3] Controller keeps CKE high during MRS, MPR, ZQ, DLL lock, bursts.
// [RL4] CKE may fall during activate/precharge/refresh; device finishes them.
// [RL5] Controller resets DLL after exit if DLL was unlocked at entry.
// [RL6] All banks closed gives precharge power-down, else active power-down.
// [RL7] Entry disables buffers except clock, ODT, CKE and reset.
// [RL8] NOP during quiet period; receivers off only after it elapses.
// [RL9] Precharge with bit clear: DLL off, slow exit, tXP and tXPDLL.
// [RL10] Active or bit set: DLL stays on, fast exit after tXP.
// [RL11] Reset low in power-down exits to reset state.
// [RL12] Controller holds CKE low, reset high, clock stable in power-down.
// [RL13] Controller waits tPD(min) after entry before exit.
// [RL14] Controller limits power-down to nine refresh intervals.
// [RL15] Exit when CKE registered high with NOP; commands after tXP/tXPDLL.
// [RL16] Refresh between exit and entry needs tXP; re-entry waits tXPDLL.
// [RL17] After early entry post refresh, only NOP until tRFC elapsed.
// [RL18] Controller should enter power-down with DLL locked.
// [RL19] Controller counts timing parameters with down-counters.
`include "dpdc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module dpdc_top (
    input wire logic sys_clk_i,                 // System clock 200 MHz
    input wire logic rst_n_i,                   // Sync reset, active low
    input wire logic ck_i,                      // Link clock CK
    input wire logic cke_i,                     // Clock enable pin
    input wire logic reset_pin_n_i,             // Device reset pin
    input wire logic cmd_nop_i,                 // Command is NOP/deselect
    input wire logic [`DPDC_BANKS-1:0] bank_open_i, // Open banks
    input wire logic bank_busy_i,               // Act/pre/ref still running
    input wire logic dll_on_in_precharge_pd_bit_i, // Mode reg zero bit
    input wire logic dll_locked_i,              // DLL locked
    output logic power_down_state_o,            // In power-down
    output logic active_pd_o,                   // Active power-down
    output logic dll_enable_o,                  // DLL kept running
    output logic io_buf_en_o,                   // General I/O buffers on
    output logic cmd_rx_en_o,                   // Command/address receivers
    output logic nodll_cmd_ok_o,                // tXP satisfied
    output logic dll_cmd_ok_o,                  // tXPDLL satisfied
    output logic dll_reset_needed_o,            // Entered with DLL unlocked
    output logic in_reset_o                     // Reset state
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        dpdc_pkg::dpdc_state_t st;
        dpdc_pkg::dpdc_pdkind_t kind;
        logic [`DPDC_CNT_W-1:0] quiet;
        logic [`DPDC_CNT_W-1:0] xp;
        logic [`DPDC_CNT_W-1:0] xpdll;
        logic pd;
        logic act;
        logic dll;
        logic iob;
        logic rx;
        logic ok;
        logic okd;
        logic dllrst;
        logic rst;
    } dpdc_regs_t;

    dpdc_regs_t r_q, r_d;
    dpdc_sync_if sy ();

    // ****************************************
    // Pin sampling
    // ****************************************
    dpdc_pin_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ck_i(ck_i),
        .cke_i(cke_i),
        .reset_pin_n_i(reset_pin_n_i),
        .cmd_nop_i(cmd_nop_i),
        .out(sy.src)
    );

    // Down-counter step saturating at zero
    function automatic logic [`DPDC_CNT_W-1:0] dec(
        input logic [`DPDC_CNT_W-1:0] v);
        dec = (v == '0) ? v : v - 1'b1;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        r_d = r_q;
        r_d.quiet = dec(r_q.quiet);
        r_d.xp = dec(r_q.xp);
        r_d.xpdll = dec(r_q.xpdll);
        unique case (r_q.st)
            dpdc_pkg::DPDC_ST_IDLE: begin
                // [RL2] Entry on CK edge
                if (sy.ck_rise && !sy.cke && sy.cmd_nop) begin
                    r_d.st = dpdc_pkg::DPDC_ST_QUIET;
                    r_d.pd = 1'b1;
                    // [RL7] Buffer gating
                    r_d.iob = 1'b0;
                    r_d.quiet = `DPDC_CNT_W'(`DPDC_TCPDED_CYC);
                    r_d.dllrst = !dll_locked_i;
                end
            end
            dpdc_pkg::DPDC_ST_QUIET: begin
                // A CKE rise seen here is ignored, with no error flag
                // [RL8] Receivers off after quiet period
                if (r_q.quiet == '0) begin
                    r_d.rx = 1'b0;
                    r_d.st = dpdc_pkg::DPDC_ST_PD;
                end
            end
            dpdc_pkg::DPDC_ST_PD: begin
                // [RL15] Exit on CKE high with NOP
                if (sy.ck_rise && sy.cke && sy.cmd_nop) begin
                    r_d.st = dpdc_pkg::DPDC_ST_EXIT;
                    r_d.pd = 1'b0;
                    r_d.iob = 1'b1;
                    r_d.rx = 1'b1;
                    r_d.ok = 1'b0;
                    r_d.okd = 1'b0;
                    r_d.dll = 1'b1;
                    // Class only means something while powered down
                    r_d.act = 1'b0;
                    r_d.xp = `DPDC_CNT_W'(`DPDC_TXP_CYC);
                    // [RL9] Slow exit waits tXPDLL
                    r_d.xpdll = (r_q.kind == dpdc_pkg::DPDC_PD_PRE_SLOW)
                        ? `DPDC_CNT_W'(`DPDC_TXPDLL_CYC)
                        : `DPDC_CNT_W'(`DPDC_TXP_CYC);
                end
            end
            dpdc_pkg::DPDC_ST_EXIT: begin
                // [RL10] Fast exit needs only tXP
                if (r_q.xp == '0) begin
                    r_d.ok = 1'b1;
                end
                if (r_q.xpdll == '0 && r_q.xp == '0) begin
                    r_d.okd = 1'b1;
                    r_d.st = dpdc_pkg::DPDC_ST_IDLE;
                    r_d.kind = dpdc_pkg::DPDC_PD_NONE;
                    r_d.act = 1'b0;
                end
            end
            dpdc_pkg::DPDC_ST_RESET: begin
                // Stay until the reset pin is released
                if (sy.reset_n) begin
                    r_d.st = dpdc_pkg::DPDC_ST_IDLE;
                    r_d.rst = 1'b0;
                    r_d.iob = 1'b1;
                    r_d.rx = 1'b1;
                    r_d.ok = 1'b1;
                    r_d.okd = 1'b1;
                    r_d.dll = 1'b1;
                end
            end
            default: begin
                r_d.st = dpdc_pkg::DPDC_ST_IDLE;
            end
        endcase
        // [RL4] [RL6] Classify once in-progress work ends
        // Skipped on the exit cycle, so the DLL restart there stands
        // and a slow exit does not leave the DLL off afterwards
        if (r_q.pd && r_d.pd && !bank_busy_i) begin
            if (bank_open_i != '0) begin
                r_d.kind = dpdc_pkg::DPDC_PD_ACTIVE;
                r_d.act = 1'b1;
                r_d.dll = 1'b1;
            end else if (dll_on_in_precharge_pd_bit_i) begin
                r_d.kind = dpdc_pkg::DPDC_PD_PRE_FAST;
                r_d.act = 1'b0;
                r_d.dll = 1'b1;
            end else begin
                r_d.kind = dpdc_pkg::DPDC_PD_PRE_SLOW;
                r_d.act = 1'b0;
                r_d.dll = 1'b0;
            end
        end
        // [RL11] Reset pin aborts power-down
        if (!sy.reset_n) begin
            r_d.st = dpdc_pkg::DPDC_ST_RESET;
            r_d.rst = 1'b1;
            r_d.pd = 1'b0;
            r_d.act = 1'b0;
            r_d.kind = dpdc_pkg::DPDC_PD_NONE;
            r_d.dllrst = 1'b0;
        end
        if (!rst_n_i) begin
            r_d = '0;
            r_d.st = dpdc_pkg::DPDC_ST_IDLE;
            r_d.dll = 1'b1;
            r_d.iob = 1'b1;
            r_d.rx = 1'b1;
            r_d.ok = 1'b1;
            r_d.okd = 1'b1;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Single register stage for all state
    always_ff @(posedge sys_clk_i) begin
        r_q <= r_d;
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Outputs straight from flip-flops
    assign power_down_state_o = r_q.pd;
    assign active_pd_o = r_q.act;
    assign dll_enable_o = r_q.dll;
    assign io_buf_en_o = r_q.iob;
    assign cmd_rx_en_o = r_q.rx;
    assign nodll_cmd_ok_o = r_q.ok;
    assign dll_cmd_ok_o = r_q.okd;
    assign dll_reset_needed_o = r_q.dllrst;
    assign in_reset_o = r_q.rst;
endmodule // dpdc_top
`default_nettype wire

//--- verilog/dpdc_cfg.svh
// Purpose: Timing counts and bit positions for the power-down control block
// Assumes: Counts are in sys_clk_i cycles at 200 MHz (5 ns period)
// Notes:   Times are in picoseconds; counts derive from them
`ifndef DPDC_CFG_SVH
`define DPDC_CFG_SVH

// Clock period in ps
`define DPDC_CLK_PS 5000
// Quiet time after CKE falls before receivers turn off, ps (least time)
`define DPDC_TCPDED_PS 10000
`define DPDC_TCPDED_CYC ((`DPDC_TCPDED_PS + `DPDC_CLK_PS - 1) / `DPDC_CLK_PS)
// Exit latency for commands not needing the DLL, ps
`define DPDC_TXP_PS 24000
`define DPDC_TXP_CYC ((`DPDC_TXP_PS + `DPDC_CLK_PS - 1) / `DPDC_CLK_PS)
// Exit latency for commands needing the DLL, ps
`define DPDC_TXPDLL_PS 24000
`define DPDC_TXPDLL_CYC ((`DPDC_TXPDLL_PS + `DPDC_CLK_PS - 1) / `DPDC_CLK_PS)
// Counter width
`define DPDC_CNT_W 8
// Command encodings {cs_n, ras_n, cas_n, we_n}
`define DPDC_CMD_NOP 4'h7
// Position of the DLL-on-in-precharge bit in mode register zero
`define DPDC_DLL_BIT 12
// Bank count
`define DPDC_BANKS 8
// Synchroniser reset value {ck, cke, reset_n, nop}: idle pin levels
`define DPDC_PIN_IDLE 4'h7

`endif

//--- verilog/dpdc_pkg.sv
// Purpose: Types for the power-down control block
// Assumes: dpdc_cfg.svh supplies the numbers
// Notes:   Types only
`include "dpdc_cfg.svh"
`default_nettype none
package dpdc_pkg;

    // Power state of the device
    typedef enum logic [2:0] {
        DPDC_ST_IDLE = 3'b000,
        DPDC_ST_QUIET = 3'b001,
        DPDC_ST_PD = 3'b010,
        DPDC_ST_EXIT = 3'b011,
        DPDC_ST_RESET = 3'b100
    } dpdc_state_t;

    // Power-down flavour
    typedef enum logic [1:0] {
        DPDC_PD_NONE = 2'b00,
        DPDC_PD_ACTIVE = 2'b01,
        DPDC_PD_PRE_FAST = 2'b10,
        DPDC_PD_PRE_SLOW = 2'b11
    } dpdc_pdkind_t;

    // Synchroniser state
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [1:0] ck;
    } dpdc_sync_t;

endpackage
`default_nettype wire

//--- verilog/dpdc_sync_if.sv
// Purpose: Carries synchronised link pins from sampler to control logic
// Assumes: One clock domain, sys_clk_i
// Notes:   ck_rise pulses one cycle per CK rising edge
`timescale 1ns/10ps
`default_nettype none
interface dpdc_sync_if;
    logic ck_rise;
    logic cke;
    logic reset_n;
    logic cmd_nop;
    modport src (output ck_rise, output cke, output reset_n, output cmd_nop);
    modport dst (input ck_rise, input cke, input reset_n, input cmd_nop);
endinterface
`default_nettype wire

//--- verilog/dpdc_pin_sync.sv
// Purpose: Two-flop synchronise link pins and find CK rising edges
// Assumes: Pins are asynchronous to sys_clk_i
// Notes:   First stage is read only by the second stage
`include "dpdc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module dpdc_pin_sync (
    input wire logic sys_clk_i,       // System clock
    input wire logic rst_n_i,         // Sync reset, active low
    input wire logic ck_i,            // Link clock pin
    input wire logic cke_i,           // Clock enable pin
    input wire logic reset_pin_n_i,   // Device reset pin, active low
    input wire logic cmd_nop_i,       // Command decodes to NOP/deselect
    dpdc_sync_if.src out              // Synchronised view
);
    dpdc_pkg::dpdc_sync_t st_q, st_d;

    // Two stages, then edge detect on the second stage only
    always_comb begin
        st_d = st_q;
        st_d.s1 = {ck_i, cke_i, reset_pin_n_i, cmd_nop_i};
        st_d.s2 = st_q.s1;
        st_d.ck = {st_q.ck[0], st_q.s2[3]};
        // Idle levels, so no false reset or entry follows reset release
        if (!rst_n_i) begin
            st_d = '0;
            st_d.s1 = `DPDC_PIN_IDLE;
            st_d.s2 = `DPDC_PIN_IDLE;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st_q <= st_d;
    end

    // Samples taken on a CK rise use the second-stage copy of the other pins, one cycle newer than the CK copy
    assign out.ck_rise = st_q.ck[0] & ~st_q.ck[1];
    assign out.cke = st_q.s2[2];
    assign out.reset_n = st_q.s2[1];
    assign out.cmd_nop = st_q.s2[0];
endmodule // dpdc_pin_sync
`default_nettype wire

//--- sim/dpdc_checker.sv
// Purpose: Assertions on the power-down control outputs
// Assumes: One clock domain; counts from dpdc_cfg.svh
// Notes:   Attached to dpdc_top by the bind after the module
`include "dpdc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module dpdc_checker (
    input wire logic sys_clk_i, // System clock
    input wire logic rst_n_i, // Sync reset, active low
    input wire logic cke_i, // Clock enable pin
    input wire logic reset_pin_n_i, // Device reset pin
    input wire logic [`DPDC_BANKS-1:0] bank_open_i, // Open banks
    input wire logic bank_busy_i, // Bank ops still running
    input wire logic dll_on_in_precharge_pd_bit_i, // Mode bit
    input wire logic power_down_state_o, // In power-down
    input wire logic active_pd_o, // Active class
    input wire logic dll_enable_o, // DLL running
    input wire logic io_buf_en_o, // I/O buffers on
    input wire logic cmd_rx_en_o, // Receivers on
    input wire logic nodll_cmd_ok_o, // tXP elapsed
    input wire logic dll_cmd_ok_o, // tXPDLL elapsed
    input wire logic in_reset_o // Reset state
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [4:0] rst_lo_q;
    // Cycles that RESET# has been low, saturating
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || reset_pin_n_i) begin
            rst_lo_q <= 5'h00;
        end else if (rst_lo_q != 5'h1F) begin
            rst_lo_q <= rst_lo_q + 5'h01;
        end
    end
    // Exit step without a device reset
    sequence s_exit;
        $fell(power_down_state_o) && !in_reset_o;
    endsequence
    // Wait step: no command grant for four cycles, then a grant within four more
    sequence s_xp_wait;
        !nodll_cmd_ok_o [*4] ##[1:4] nodll_cmd_ok_o;
    endsequence
    a_buf_off_pd: assert property (power_down_state_o |-> !io_buf_en_o)
        else $error("io buffers on in power-down");
    a_rx_quiet: assert property ($rose(power_down_state_o) |-> cmd_rx_en_o [*2])
        else $error("receivers off inside quiet time");
    a_rx_off_bound: assert property ($rose(power_down_state_o) |->
        ##[1:6] (!cmd_rx_en_o || !power_down_state_o))
        else $error("receivers not switched off");
    a_entry_cke_low: assert property ($rose(power_down_state_o) |->
        !cke_i && ($past(cke_i, 3) == 1'b0))
        else $error("power-down without CKE low");
    a_class_active: assert property ((power_down_state_o && !bank_busy_i
        && (|bank_open_i)) [*3] |-> active_pd_o && dll_enable_o)
        else $error("open bank not active power-down");
    a_class_slow: assert property ((power_down_state_o && !bank_busy_i
        && !(|bank_open_i) && !dll_on_in_precharge_pd_bit_i) [*3]
        |-> !active_pd_o && !dll_enable_o)
        else $error("slow precharge class wrong");
    a_fast_dll_on: assert property ((power_down_state_o
        && dll_on_in_precharge_pd_bit_i) [*3] |-> dll_enable_o)
        else $error("dll off with bit set");
    a_exit_xp: assert property (s_exit |-> s_xp_wait)
        else $error("exit latency wrong");
    a_dll_ok_order: assert property (dll_cmd_ok_o |-> nodll_cmd_ok_o)
        else $error("tXPDLL before tXP");
    a_reset_leaves: assert property ((rst_lo_q == 5'h14) |->
        in_reset_o && !power_down_state_o)
        else $error("RESET# low did not reset");
endmodule // dpdc_checker
bind dpdc_top dpdc_checker dpdc_checker_i (.sys_clk_i, .rst_n_i, .cke_i,
    .reset_pin_n_i, .bank_open_i, .bank_busy_i, .dll_on_in_precharge_pd_bit_i,
    .power_down_state_o, .active_pd_o, .dll_enable_o, .io_buf_en_o,
    .cmd_rx_en_o, .nodll_cmd_ok_o, .dll_cmd_ok_o, .in_reset_o);
`default_nettype wire

//--- sim/dpdc_ctrl_model.sv
// Purpose: Controller model driving CK, CKE, command and RESET#
// Assumes: CK runs free, 48 ns; pins change on CK falling edges
// Notes:   HOLD_CK covers tCKE, quiet and exit latencies in CK cycles
`timescale 1ns/10ps
`default_nettype none
module dpdc_ctrl_model #(
    parameter int HOLD_CK = 3
) (
    input wire logic want_pd_i, // Request power-down
    input wire logic want_rst_i, // Request device reset
    output logic ck_o, // Link clock
    output logic cke_o, // Clock enable
    output logic cmd_nop_o, // NOP or deselect on bus
    output logic reset_pin_n_o // Device reset, active low
);
    int hold;
    initial begin
        ck_o = 1'b0;
        cke_o = 1'b1;
        cmd_nop_o = 1'b1;
        reset_pin_n_o = 1'b1;
        hold = 0;
        forever #24 ck_o = ~ck_o;
    end
    always @(negedge ck_o) begin
        reset_pin_n_o <= !want_rst_i;
        if (hold != 0) begin
            hold <= hold - 1;
        end else if (want_pd_i == cke_o) begin
            // no bursts or self-refresh, so CKE may fall
            cke_o <= !want_pd_i;
            cmd_nop_o <= 1'b1;
            hold <= HOLD_CK;
        end else begin
            // Real commands while awake, so NOP is not a constant
            cmd_nop_o <= !cke_o;
        end
    end
endmodule // dpdc_ctrl_model
`default_nettype wire

//--- sim/dpdc_top_tb.sv
// Purpose: Self-checking bench for power-down entry and exit
// Assumes: 200 MHz system clock, controller model on the pins
// Notes:   Outputs sampled on falling edges, inputs driven on rising
`timescale 1ns/10ps
`default_nettype none
module dpdc_top_tb;
    localparam int LIMIT = 20000;
    logic sys_clk_i, rst_n_i, ck, cke, nop, rpin_n, busy, dbit, lock;
    logic want_pd, want_rst, pd, act, dlle, iob, rx, ok, okd, dllrst, inrst;
    logic [7:0] bank_open;
    int err_count, checks, cyc;
    dpdc_top dpdc_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .ck_i(ck), .cke_i(cke), .reset_pin_n_i(rpin_n), .cmd_nop_i(nop),
        .bank_open_i(bank_open), .bank_busy_i(busy),
        .dll_on_in_precharge_pd_bit_i(dbit), .dll_locked_i(lock),
        .power_down_state_o(pd), .active_pd_o(act), .dll_enable_o(dlle),
        .io_buf_en_o(iob), .cmd_rx_en_o(rx), .nodll_cmd_ok_o(ok),
        .dll_cmd_ok_o(okd), .dll_reset_needed_o(dllrst), .in_reset_o(inrst));
    dpdc_ctrl_model dpdc_ctrl_model_i (.want_pd_i(want_pd),
        .want_rst_i(want_rst), .ck_o(ck), .cke_o(cke), .cmd_nop_o(nop),
        .reset_pin_n_o(rpin_n));
    // System clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // Verdict and end of run
    task automatic end_sim;
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Compare one bit, four-state exact
    task automatic chk(input logic seen, input logic exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    // Bank and DLL conditions for the next entry
    task automatic set_cond(input logic [7:0] o, input logic b, input logic l,
        input logic bz);
        @(posedge sys_clk_i);
        bank_open <= o;
        dbit <= b;
        lock <= l;
        busy <= bz;
    endtask
    // Ask for entry or exit, wait bounded, then let timers settle
    task automatic go_pd(input logic v);
        int n;
        @(posedge sys_clk_i);
        want_pd <= v;
        n = 0;
        while (pd !== v && n < 2000) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(pd, v, "power-down level");
        // stay kept far below nine refresh intervals
        repeat (10) @(negedge sys_clk_i);
    endtask
    // Active power-down with an open bank
    task automatic sc_active;
        set_cond(8'h01, 1'b0, 1'b1, 1'b0);
        go_pd(1'b1);
        chk(act, 1'b1, "active class");
        chk(dlle, 1'b1, "dll kept on");
        chk(iob, 1'b0, "io buffers off");
        chk(rx, 1'b0, "receivers off");
        go_pd(1'b0);
        chk(ok, 1'b1, "exit latency done");
        chk(rx, 1'b1, "receivers back");
        chk(iob, 1'b1, "io buffers back");
        chk(act, 1'b0, "active class cleared");
    endtask
    // Slow precharge power-down entered while a bank op still runs
    task automatic sc_slow;
        set_cond(8'h00, 1'b0, 1'b0, 1'b1);
        go_pd(1'b1);
        set_cond(8'h00, 1'b0, 1'b0, 1'b0);
        repeat (4) @(negedge sys_clk_i);
        chk(act, 1'b0, "precharge class");
        chk(dlle, 1'b0, "dll off in slow exit");
        chk(dllrst, 1'b1, "dll reset flagged");
        go_pd(1'b0);
        chk(okd, 1'b1, "dll latency done");
        chk(dlle, 1'b1, "dll back on after exit");
    endtask
    // Fast precharge power-down with the mode bit set
    task automatic sc_fast;
        set_cond(8'h00, 1'b1, 1'b1, 1'b0);
        go_pd(1'b1);
        chk(act, 1'b0, "precharge class");
        chk(dlle, 1'b1, "dll on in fast exit");
        go_pd(1'b0);
        chk(ok, 1'b1, "exit latency done");
    endtask
    // RESET# low in power-down
    task automatic sc_reset;
        set_cond(8'h80, 1'b0, 1'b0, 1'b0);
        go_pd(1'b1);
        chk(dllrst, 1'b1, "dll flag set");
        @(posedge sys_clk_i);
        want_rst <= 1'b1;
        repeat (30) @(negedge sys_clk_i);
        chk(inrst, 1'b1, "reset state");
        chk(pd, 1'b0, "left power-down");
        chk(dllrst, 1'b0, "dll flag cleared");
    endtask
    // Cycle ceiling against hangs
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            end_sim();
        end
    end
    // Reset, then scenarios in turn
    initial begin
        err_count = 0;
        checks = 0;
        cyc = 0;
        rst_n_i = 1'b0;
        bank_open = 8'h00;
        busy = 1'b0;
        dbit = 1'b0;
        lock = 1'b1;
        want_pd = 1'b0;
        want_rst = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        sc_active();
        sc_slow();
        sc_fast();
        sc_reset();
        end_sim();
    end
endmodule // dpdc_top_tb
`default_nettype wire
